// ===== design/cmpc_pkg.sv
// package for the comparator control block: register map, fields, resets
// assumes a 32-bit apb bus with word-aligned registers
package cmpc_pkg;
	// register byte addresses
	localparam logic [11:0] ADDR_CTRL = 12'hf90; // comparator control
	localparam logic [11:0] ADDR_STAT = 12'hf94; // sticky event status
	localparam logic [11:0] ADDR_MASK = 12'hf98; // interrupt mask
	localparam logic [11:0] ADDR_PWR = 12'hf9c; // power and output route
	// control register fields
	localparam int POS_SEL_BIT = 7; // positive input select
	localparam int NEG_SEL_BIT = 6; // negative input select
	localparam int LVL_LSB = 2; // reference level low bit
	localparam int LVL_MSB = 5; // reference level high bit
	localparam logic [7:0] CTRL_RESET = 8'h14; // level 0101, pins selected
	localparam logic [7:0] CTRL_WMASK = 8'hfc; // low two bits reserved
	localparam logic [3:0] LVL_MAX = 4'h9; // highest legal level code
	// status and mask fields
	localparam int EVT_CHANGE_BIT = 0; // comparator output toggled
	localparam int EVT_RSVD_BIT = 1; // reserved level code written
	localparam int EVT_W = 2; // number of event bits
	localparam logic [1:0] EVT_RESET = 2'h0; // status reset value
	localparam logic [1:0] MASK_RESET = 2'h0; // mask reset value
	// power register fields
	localparam int PWR_DOWN_BIT = 0; // comparator powered down
	localparam int PIN_ROUTE_BIT = 1; // result routed to pin mux
	localparam logic [1:0] PWR_RESET = 2'h1; // powered down after reset
endpackage : cmpc_pkg

// ===== design/cmpc_sync.sv
// two-flop synchroniser for the asynchronous comparator output
// assumes pclk is free running
`timescale 1ns/1ns
module cmpc_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_r; // first stage, read only by the second
	logic meta_nxt;
	logic sync_r; // second stage
	logic sync_nxt;

	// next values simply shift along
	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;
endmodule : cmpc_sync

// ===== design/cmpc_irq.sv
// sticky status bits with write-one-to-clear, masked onto one irq level
// assumes event pulses are one cycle wide and synchronous to pclk
`timescale 1ns/1ns
module cmpc_irq #(
	parameter int W = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] evt_set,
	input wire logic [W-1:0] clr_bits,
	input wire logic [W-1:0] mask,
	output logic [W-1:0] status,
	output logic irq
);
	logic [W-1:0] stat_r; // sticky event bits
	logic [W-1:0] stat_nxt;

	// at least one event bit is needed for the level to mean anything
	if (W < 1) begin : g_bad_width
		$error("event width must be at least one");
	end

	// a set in the same cycle as its clear wins, so no event is lost
	always_comb begin
		stat_nxt = (stat_r & ~clr_bits) | evt_set;
	end

	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= '0;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	assign status = stat_r;
	assign irq = |(stat_r & mask);

	// set wins over clear
	chk_set_beats_clear: assert property ( // [RULE9]
		@(posedge pclk) disable iff (!presetn)
		(evt_set != '0) |=> ((stat_r & $past(evt_set)) == $past(evt_set)))
		else $error("event set lost");
	// an unmasked event raises the level unless the mask moved
	chk_irq_level: assert property ( // [RULE6]
		@(posedge pclk) disable iff (!presetn)
		((evt_set & mask) != '0) |=> (irq || (mask != $past(mask))))
		else $error("unmasked event did not raise irq");
endmodule : cmpc_irq

// ===== design/cmpc_top.sv
// comparator control: apb registers, input steering, event interrupt
// assumes apb slave on pclk; analog result arrives asynchronously
//
// What this block does
// RULE1: positive select picks pin or temperature sensor
// RULE2: negative select picks pin or internal reference
// RULE3: four-bit level sets reference, 0.2 V steps
// RULE4: reference level resets to code 0101
// RULE5: comparator level independent of converter reference
// RULE6: result drives interrupt and pin route
// RULE7: separate power control can power comparator down
// RULE8: software masks irq while enabling, then clears
// RULE9: synchronise output; request on every change; changes while powered down raise none
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
module cmpc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic comparator_result, // raw analog comparator output
	output logic positive_input_select, // 1 = temperature sensor
	output logic negative_input_select, // 1 = internal reference
	output logic [3:0] reference_level, // reference code to the dac
	output logic comparator_power_down, // 1 = analog part off
	output logic result_to_pin, // synchronised result for gpio mux
	output logic result_pin_enable, // gpio mux alternate function select
	output logic irq
);
	logic [7:0] ctrl_r; // comparator_control register
	logic [7:0] ctrl_nxt;
	logic [1:0] pwr_r; // power-down and pin route
	logic [1:0] pwr_nxt;
	logic [cmpc_pkg::EVT_W-1:0] mask_r; // interrupt mask
	logic [cmpc_pkg::EVT_W-1:0] mask_nxt;
	logic res_q_r; // previous synchronised result
	logic res_q_nxt;
	logic res_sync; // synchronised comparator output
	logic wr_en; // apb write this cycle
	logic wr_ctrl; // write to the control word
	logic wr_pwr; // write to the power word
	logic wr_mask; // write to the mask word
	logic rd_hit; // address maps to a register
	logic [cmpc_pkg::EVT_W-1:0] evt; // event pulses
	logic [cmpc_pkg::EVT_W-1:0] clr; // write-one-to-clear bits
	logic [cmpc_pkg::EVT_W-1:0] stat; // sticky status
	logic [31:0] rd_mux; // read data before the output flop
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;

	// true when a byte lane holding the low byte is written
	function automatic logic lane0(input logic [3:0] s);
		return s[0];
	endfunction : lane0

	// access phase completes in one cycle, no wait states
	assign wr_en = psel && penable && pwrite && lane0(pstrb);
	assign pready = 1'b1;
	// per-register write strobes, used by the reserved-code flag and the checks
	assign wr_ctrl = wr_en && (paddr == cmpc_pkg::ADDR_CTRL);
	assign wr_pwr = wr_en && (paddr == cmpc_pkg::ADDR_PWR);
	assign wr_mask = wr_en && (paddr == cmpc_pkg::ADDR_MASK);

	// the level field must match the four-bit level port
	if ((cmpc_pkg::LVL_MSB - cmpc_pkg::LVL_LSB + 1) !=
		$bits(reference_level)) begin : g_bad_level
		$error("level field does not match level port");
	end
	// the reserved-code flag needs its own status bit
	if (cmpc_pkg::EVT_W <= cmpc_pkg::EVT_RSVD_BIT) begin : g_bad_evt
		$error("event width too small for the reserved flag");
	end

	// decode of the four mapped words
	always_comb begin
		rd_hit = (paddr == cmpc_pkg::ADDR_CTRL) ||
			(paddr == cmpc_pkg::ADDR_STAT) ||
			(paddr == cmpc_pkg::ADDR_MASK) ||
			(paddr == cmpc_pkg::ADDR_PWR);
	end
	// unmapped address answers with an error in the access phase
	// writes there are dropped by the default branch of the write case
	assign pslverr = psel && penable && !rd_hit;

	// synchronise the analog output before any use [RULE9]
	// a raw edge could otherwise be seen differently by two flops
	cmpc_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(comparator_result),
		.sync_out(res_sync)
	);

	// register write next values
	always_comb begin
		ctrl_nxt = ctrl_r;
		pwr_nxt = pwr_r;
		mask_nxt = mask_r;
		clr = '0;
		if (wr_en) begin
			case (paddr)
				cmpc_pkg::ADDR_CTRL: begin
					// reserved low bits stay zero
					ctrl_nxt = pwdata[7:0] & cmpc_pkg::CTRL_WMASK;
				end
				cmpc_pkg::ADDR_STAT: begin
					// ones clear, zeros leave pending bits alone
					clr = pwdata[cmpc_pkg::EVT_W-1:0];
				end
				cmpc_pkg::ADDR_MASK: begin
					// one enable per status bit
					mask_nxt = pwdata[cmpc_pkg::EVT_W-1:0];
				end
				cmpc_pkg::ADDR_PWR: begin
					pwr_nxt = pwdata[cmpc_pkg::PIN_ROUTE_BIT:
						cmpc_pkg::PWR_DOWN_BIT]; // [RULE7]
				end
				default: begin
					ctrl_nxt = ctrl_r; // unmapped, nothing stored
				end
			endcase
		end
	end

	// change detector on the synchronised result
	always_comb begin
		res_q_nxt = res_sync;
		evt = '0;
		// res_q_r resets low, the powered-down level: no false edge
		// a toggle is a request; powered down output is ignored
		evt[cmpc_pkg::EVT_CHANGE_BIT] = (res_sync != res_q_r) &&
			!pwr_r[cmpc_pkg::PWR_DOWN_BIT]; // [RULE9] [RULE6]
		// flag reserved level codes so software sees the misuse
		evt[cmpc_pkg::EVT_RSVD_BIT] = wr_ctrl &&
			(pwdata[cmpc_pkg::LVL_MSB:cmpc_pkg::LVL_LSB] >
			cmpc_pkg::LVL_MAX); // [RULE3]
	end

	// status and mask; software masks before enabling [RULE8]
	cmpc_irq #(
		.W(cmpc_pkg::EVT_W)
	) u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.evt_set(evt),
		.clr_bits(clr),
		.mask(mask_r),
		.status(stat),
		.irq(irq) // [RULE6]
	);

	// read mux, low bits only, upper bits zero
	always_comb begin
		rd_mux = 32'h0;
		case (paddr)
			cmpc_pkg::ADDR_CTRL: rd_mux[7:0] = ctrl_r;
			cmpc_pkg::ADDR_STAT: rd_mux[cmpc_pkg::EVT_W-1:0] = stat;
			cmpc_pkg::ADDR_MASK: rd_mux[cmpc_pkg::EVT_W-1:0] = mask_r;
			cmpc_pkg::ADDR_PWR: rd_mux[cmpc_pkg::PIN_ROUTE_BIT:
				cmpc_pkg::PWR_DOWN_BIT] = pwr_r;
			default: rd_mux = 32'h0;
		endcase
		// read data is captured in the setup cycle
		// and held until the next read, so a slow master still sees it
		prdata_nxt = (psel && !penable && !pwrite) ? rd_mux : prdata_r;
	end

	// registers
	// the reset branch loads package constants, and zero for res_q_r and prdata_r
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= cmpc_pkg::CTRL_RESET; // [RULE4]
			pwr_r <= cmpc_pkg::PWR_RESET;
			mask_r <= cmpc_pkg::MASK_RESET;
			res_q_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			ctrl_r <= ctrl_nxt;
			pwr_r <= pwr_nxt;
			mask_r <= mask_nxt;
			res_q_r <= res_q_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// steering outputs straight from the control fields
	assign positive_input_select = ctrl_r[cmpc_pkg::POS_SEL_BIT]; // [RULE1]
	assign negative_input_select = ctrl_r[cmpc_pkg::NEG_SEL_BIT]; // [RULE2]
	// only this register drives the level; no converter input reaches it
	assign reference_level =
		ctrl_r[cmpc_pkg::LVL_MSB:cmpc_pkg::LVL_LSB]; // [RULE3] [RULE5]
	assign comparator_power_down = pwr_r[cmpc_pkg::PWR_DOWN_BIT]; // [RULE7]
	assign result_to_pin = res_q_r; // [RULE6]
	assign result_pin_enable = pwr_r[cmpc_pkg::PIN_ROUTE_BIT]; // [RULE6]
	assign prdata = prdata_r;

	// reset values
	// reset leaves both inputs on their pins
	chk_sel_reset: assert property ( // [RULE1] [RULE2]
		@(posedge pclk) $rose(presetn) |->
		!positive_input_select && !negative_input_select)
		else $error("input selects not cleared by reset");
	// reference level comes up at the middle code
	chk_level_reset: assert property ( // [RULE4]
		@(posedge pclk) $rose(presetn) |->
		reference_level ==
		cmpc_pkg::CTRL_RESET[cmpc_pkg::LVL_MSB:cmpc_pkg::LVL_LSB])
		else $error("reference level not 0101 after reset");
	// comparator starts powered down and off the pin
	chk_power_reset: assert property ( // [RULE7]
		@(posedge pclk) $rose(presetn) |->
		comparator_power_down && !result_pin_enable)
		else $error("power control not at reset value");

	// register writes
	// every control write lands on the positive select output
	chk_pos_select: assert property ( // [RULE1]
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> positive_input_select ==
		$past(pwdata[cmpc_pkg::POS_SEL_BIT]))
		else $error("positive select not updated");
	// the negative side follows its own bit
	chk_neg_select: assert property ( // [RULE2]
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> negative_input_select ==
		$past(pwdata[cmpc_pkg::NEG_SEL_BIT]))
		else $error("negative select not updated");
	// selects move only on a control write
	chk_sel_hold: assert property ( // [RULE1] [RULE2]
		@(posedge pclk) disable iff (!presetn)
		!wr_ctrl |=> $stable(positive_input_select) &&
		$stable(negative_input_select))
		else $error("input select changed without write");
	// reserved codes are stored as written, not clipped
	chk_level_write: assert property ( // [RULE3]
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> reference_level ==
		$past(pwdata[cmpc_pkg::LVL_MSB:cmpc_pkg::LVL_LSB]))
		else $error("reference level not written");
	// a reserved code raises its status flag
	chk_rsvd_flag: assert property ( // [RULE3]
		@(posedge pclk) disable iff (!presetn)
		(wr_ctrl && (pwdata[cmpc_pkg::LVL_MSB:cmpc_pkg::LVL_LSB] >
		cmpc_pkg::LVL_MAX)) |=> stat[cmpc_pkg::EVT_RSVD_BIT])
		else $error("reserved level code not flagged");
	// nothing else may move the level, the converter least of all
	chk_level_hold: assert property ( // [RULE5]
		@(posedge pclk) disable iff (!presetn)
		!wr_ctrl |=> $stable(reference_level))
		else $error("reference level changed without write");
	// the mask takes the low bits of the written word
	chk_mask_write: assert property ( // [RULE6]
		@(posedge pclk) disable iff (!presetn)
		wr_mask |=> mask_r == $past(pwdata[cmpc_pkg::EVT_W-1:0]))
		else $error("interrupt mask not written");
	// a control read returns the stored word, reserved bits zero
	chk_read_ctrl: assert property ( // [RULE3]
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == cmpc_pkg::ADDR_CTRL) |=>
		prdata == {24'h0, $past(ctrl_r)})
		else $error("control read data wrong");
	// route enable follows its bit in the power word
	chk_pin_enable: assert property ( // [RULE6]
		@(posedge pclk) disable iff (!presetn)
		wr_pwr |=> result_pin_enable ==
		$past(pwdata[cmpc_pkg::PIN_ROUTE_BIT]))
		else $error("pin route enable not written");
	// power-down follows its bit in the power word
	chk_power_write: assert property ( // [RULE7]
		@(posedge pclk) disable iff (!presetn)
		wr_pwr |=> comparator_power_down ==
		$past(pwdata[cmpc_pkg::PWR_DOWN_BIT]))
		else $error("power control not written");

	// event path
	// the synchroniser takes two edges, no more, on a rise
	chk_sync_delay: assert property ( // [RULE9]
		@(posedge pclk) disable iff (!presetn)
		$rose(comparator_result) ##1 comparator_result ##1
		comparator_result |-> res_sync)
		else $error("result not synchronised in two cycles");
	// and the same on a fall
	chk_fall_sync: assert property ( // [RULE9]
		@(posedge pclk) disable iff (!presetn)
		$fell(comparator_result) ##1 !comparator_result ##1
		!comparator_result |-> !res_sync)
		else $error("falling result not synchronised in two cycles");
	// each toggle of the powered result leaves a request
	chk_toggle_req: assert property ( // [RULE9]
		@(posedge pclk) disable iff (!presetn)
		($changed(res_sync) && !comparator_power_down) |=>
		stat[cmpc_pkg::EVT_CHANGE_BIT])
		else $error("toggle did not raise request");
	// a powered-down comparator raises no new request
	chk_quiet_down: assert property ( // [RULE7]
		@(posedge pclk) disable iff (!presetn)
		(comparator_power_down && !stat[cmpc_pkg::EVT_CHANGE_BIT]) |=>
		!stat[cmpc_pkg::EVT_CHANGE_BIT])
		else $error("request raised while powered down");
	// an unmasked request shows on irq one edge later
	chk_irq_raise: assert property ( // [RULE6]
		@(posedge pclk) disable iff (!presetn)
		(evt[cmpc_pkg::EVT_CHANGE_BIT] &&
		mask_r[cmpc_pkg::EVT_CHANGE_BIT] && !wr_mask) |=> irq)
		else $error("unmasked request did not raise irq");

	// output routing
	// the pin copy trails the synchronised result by one edge
	chk_pin_route: assert property ( // [RULE6]
		@(posedge pclk) disable iff (!presetn)
		result_to_pin == $past(res_sync))
		else $error("pin route not following result");
endmodule : cmpc_top

// ===== sim/cmpc_analog_model.sv
// far side model: input pins, sensor and the analog comparator itself
// assumes voltages in millivolts, set by the bench off the clock edge
`timescale 1ns/1ns
module cmpc_analog_model (
	input int pos_pin_mv,
	input int neg_pin_mv,
	input int temp_mv,
	input wire logic pos_sel,
	input wire logic neg_sel,
	input wire logic [3:0] level,
	input wire logic power_down,
	output logic result
);
	int vp; // positive input level
	int vn; // negative input level
	// input steering and compare, no hysteresis modelled
	always_comb begin
		vp = pos_sel ? temp_mv : pos_pin_mv;
		vn = neg_sel ? 200 * level : neg_pin_mv;
		// powered down part gives a low output, so power-up can toggle
		result = power_down ? 1'b0 : (vp > vn);
	end
endmodule : cmpc_analog_model

// ===== sim/comparator_control_tb.sv
// self-checking bench for the comparator control block
// assumes apb slave at cmpc_pkg addresses, analog model on far side
`timescale 1ns/1ns
module comparator_control_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready, pslverr, cres, pos_s, neg_s, pd, rtp, rpe, irq;
	logic [3:0] lvl;
	int pp = 500; // positive pin, mv
	int np = 300; // negative pin, mv
	int tp = 1200; // sensor output, mv
	integer seed = 68950;
	int error_cnt = 0;
	int compares = 0;
	logic [31:0] q; // last read data
	logic serr; // last slave error
	logic [7:0] v;
	logic e, pr;
	logic [7:0] cs [5] = '{8'h00, 8'h54, 8'he4, 8'h80, 8'hc4};
	logic [31:0] rv [4] = '{32'h14, 32'h0, 32'h0, 32'h1};
	cmpc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .comparator_result(cres),
		.positive_input_select(pos_s), .negative_input_select(neg_s),
		.reference_level(lvl), .comparator_power_down(pd),
		.result_to_pin(rtp), .result_pin_enable(rpe), .irq(irq));
	cmpc_analog_model mdl (.pos_pin_mv(pp), .neg_pin_mv(np),
		.temp_mv(tp), .pos_sel(pos_s), .neg_sel(neg_s), .level(lvl),
		.power_down(pd), .result(cres));
	// 125 mhz clock
	initial forever #4 pclk = ~pclk;
	// expected comparator output for a control value, powered up
	function automatic logic exp_res(input logic [7:0] c);
		int a, b;
		a = c[7] ? tp : pp;
		b = c[6] ? 200 * int'(c[5:2]) : np;
		return a > b;
	endfunction : exp_res
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task summarize;
		$display("counts: %0d compares, %0d errors", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	// one apb transfer; waits on pready with a bound
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		q = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			error_cnt++;
			summarize();
		end
	endtask : apb
	// main sequence
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, cmpc_pkg::ADDR_CTRL + 12'(4 * i), 32'h0);
			chk(q, rv[i]);
		end
		chk({pos_s, neg_s, lvl, pd, irq}, 8'h16);
		$display("reset test done");
		// every level code, random selects and reserved bits
		for (int i = 0; i < 16; i++) begin
			v = 8'($random(seed));
			v[5:2] = 4'(i);
			apb(1'b1, cmpc_pkg::ADDR_CTRL, {24'h0, v});
			apb(1'b0, cmpc_pkg::ADDR_CTRL, 32'h0);
			chk(q, {24'h0, v & 8'hfc});
			chk({pos_s, neg_s, lvl}, v[7:2]);
		end
		apb(1'b0, cmpc_pkg::ADDR_STAT, 32'h0);
		chk(q, 32'h2);
		// unmapped place and disabled strobe are refused
		apb(1'b1, 12'hfa0, 32'hff);
		chk(serr, 1'b1);
		pstrb <= 4'h0;
		apb(1'b1, cmpc_pkg::ADDR_CTRL, 32'h0);
		pstrb <= 4'hf;
		apb(1'b0, cmpc_pkg::ADDR_CTRL, 32'h0);
		chk(q, {24'h0, v & 8'hfc});
		$display("register test done");
		// safe enable: masked, power up, settle, clear, unmask
		apb(1'b1, cmpc_pkg::ADDR_CTRL, 32'h0);
		apb(1'b1, cmpc_pkg::ADDR_PWR, 32'h2);
		repeat (6) @(posedge pclk);
		apb(1'b1, cmpc_pkg::ADDR_STAT, 32'h3);
		apb(1'b1, cmpc_pkg::ADDR_MASK, 32'h1);
		pr = 1'b1;
		foreach (cs[k]) begin
			apb(1'b1, cmpc_pkg::ADDR_CTRL, {24'h0, cs[k]});
			repeat (6) @(posedge pclk);
			e = exp_res(cs[k]);
			chk({rtp, rpe}, {e, 1'b1});
			chk(irq, e != pr);
			apb(1'b0, cmpc_pkg::ADDR_STAT, 32'h0);
			chk(q, {31'h0, e != pr});
			apb(1'b1, cmpc_pkg::ADDR_STAT, 32'h1);
			@(posedge pclk);
			chk(irq, 1'b0);
			pr = e;
		end
		// masked event sets status but holds irq low
		apb(1'b1, cmpc_pkg::ADDR_MASK, 32'h0);
		tp <= 100;
		repeat (6) @(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, cmpc_pkg::ADDR_MASK, 32'h1);
		@(posedge pclk);
		chk(irq, 1'b1);
		// result high again, clear, then power down: the fall is unseen
		tp <= 1500;
		repeat (6) @(posedge pclk);
		apb(1'b1, cmpc_pkg::ADDR_STAT, 32'h1);
		apb(1'b1, cmpc_pkg::ADDR_PWR, 32'h1);
		repeat (6) @(posedge pclk);
		chk({rtp, cres}, 2'b00);
		apb(1'b0, cmpc_pkg::ADDR_STAT, 32'h0);
		chk({q[1:0], pd, rpe, irq}, 5'h04);
		$display("event test done");
		summarize();
	end
endmodule : comparator_control_tb
